// *** verilog/wrw_watchdog.sv ***
// Purpose: countdown reset watchdog with apb control register
// Assumes: pclk is both oscillator and cpu clock; halt and wake inputs are one-cycle pulses
// Notes:   the block raises no interrupt, only the reset pin
`timescale 1ns/1ps
`include "wrw_params.svh"

module wrw_watchdog #(
  parameter int OSC_DIV = `WRW_OSC_DIV
) (
  input  wire logic        pclk,                    // 200 MHz clock
  input  wire logic        presetn,                 // async reset, low
  input  wire logic        psel,                    // apb select
  input  wire logic        penable,                 // apb enable
  input  wire logic        pwrite,                  // apb direction
  input  wire logic [11:0] paddr,                   // apb byte address
  input  wire logic [31:0] pwdata,                  // apb write data
  output logic      [31:0] prdata,                  // apb read data
  output logic             pready,                  // apb ready
  output logic             pslverr,                 // apb error, unmapped
  input  wire logic        halt_insn,               // halt instruction pulse
  input  wire logic        ext_irq_wake,            // external interrupt pulse
  input  wire logic        osc_irq_wake,            // oscillator interrupt pulse
  input  wire logic        rtc_interrupt_enable,    // from clock_controller_status
  input  wire logic        halt_reset_option,       // option byte bit
  input  wire logic        hw_watchdog_option,      // option byte bit
  input  wire logic        long_restart_sel,        // 1: 4096 clocks, 0: 256
  input  wire logic        active_halt_reset_strap, // reset ended active-halt
  output logic             wdg_reset_n              // reset pin, low
);

  // ==========================================================================
  // state
  wrw_pkg::wrw_state_t state_q, state_d;
  wrw_pkg::wrw_cnt_t   cnt_q, cnt_d;
  wrw_pkg::wrw_dly_t   dly_q, dly_d;
  logic                act_q;
  logic                fire_q;
  logic                boot_q;
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;

  wrw_ctl_if ctl ();

  function automatic wrw_pkg::wrw_dly_t dly_len(input logic long_sel);
    dly_len = long_sel ? 13'(`WRW_DLY_LONG - 1) : 13'(`WRW_DLY_SHORT - 1);
  endfunction

  // ==========================================================================
  // apb decode
  wire        setup    = psel & ~penable;
  wire        access   = psel & penable & pready_q;
  wire        hit      = (paddr == `WRW_CTRL_ADDR);
  wire        sw_wr    = access & pwrite & hit;
  wire  [7:0] wr_byte  = pwdata[7:0];
  wire  [7:0] rd_byte  = {act_q, cnt_q};

  // ==========================================================================
  // activation and reset conditions
  wire act_new    = act_q | (sw_wr & wr_byte[`WRW_ACT_BIT]);
  wire active_now = act_new | hw_watchdog_option;
  wire st_run     = (state_q == wrw_pkg::WRW_RUN);
  wire st_last    = (state_q == wrw_pkg::WRW_HALT_LAST);
  wire st_halted  = (state_q == wrw_pkg::WRW_HALTED);
  wire st_ahalt   = (state_q == wrw_pkg::WRW_ACT_HALT);
  wire st_restart = (state_q == wrw_pkg::WRW_RESTART);
  wire count_en   = st_run | st_last;
  wire tick       = ctl.tick;
  wire roll       = tick & (cnt_q == `WRW_ROLL_FROM) & ~sw_wr;
  wire sw_force   = sw_wr & ~wr_byte[`WRW_TOP_BIT];
  wire halt_go    = st_run & halt_insn;
  wire halt_rst   = halt_go & ~rtc_interrupt_enable & halt_reset_option;
  wire fire_d     = active_now & st_run & (roll | sw_force | halt_rst);

  assign ctl.count_en = count_en;
  assign ctl.fire     = fire_q;

  // ==========================================================================
  // counter next value; a write wins over a tick in the same cycle
  always_comb begin
    cnt_d = cnt_q;
    if (sw_wr) begin
      cnt_d = wr_byte[6:0];
    end else if (tick & count_en) begin
      cnt_d = cnt_q - 7'h01;
    end
  end

  // ==========================================================================
  // power state sequencing
  always_comb begin
    state_d = state_q;
    dly_d   = dly_q;
    unique case (state_q)
      wrw_pkg::WRW_RUN: begin
        if (boot_q & active_halt_reset_strap) begin
          state_d = wrw_pkg::WRW_RESTART;
          dly_d   = dly_len(long_restart_sel);
        end else if (halt_go & rtc_interrupt_enable) begin
          state_d = wrw_pkg::WRW_ACT_HALT;
        end else if (halt_go & ~(halt_reset_option & active_now)) begin
          state_d = wrw_pkg::WRW_HALT_LAST;
        end
      end
      wrw_pkg::WRW_HALT_LAST: begin
        if (tick) begin
          state_d = wrw_pkg::WRW_HALTED;
        end
      end
      wrw_pkg::WRW_HALTED: begin
        if (ext_irq_wake) begin
          state_d = wrw_pkg::WRW_RESTART;
          dly_d   = dly_len(long_restart_sel);
        end
      end
      wrw_pkg::WRW_ACT_HALT: begin
        if (ext_irq_wake | osc_irq_wake) begin
          state_d = wrw_pkg::WRW_RUN;
        end
      end
      wrw_pkg::WRW_RESTART: begin
        if (dly_q == 13'h0000) begin
          state_d = wrw_pkg::WRW_RUN;
        end else begin
          dly_d = dly_q - 13'h0001;
        end
      end
      default: begin
        state_d = wrw_pkg::WRW_RUN;
      end
    endcase
  end

  // ==========================================================================
  // watchdog registers; only presetn clears activation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= wrw_pkg::WRW_RUN;
      cnt_q   <= 7'(`WRW_CTRL_RST);
      act_q   <= 1'b0;
      dly_q   <= 13'h0000;
      fire_q  <= 1'b0;
      boot_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      act_q   <= act_new;
      dly_q   <= dly_d;
      fire_q  <= fire_d;
      boot_q  <= 1'b0;
    end
  end

  // ==========================================================================
  // apb answer: zero wait states, read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b1;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setup) begin
        prdata_q  <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        pslverr_q <= ~hit;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // divider and reset pin stretcher
  wrw_prescaler #(
    .DIV     (OSC_DIV)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (ctl)
  );

  wrw_reset_pulse u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (ctl)
  );

  assign wdg_reset_n = ctl.rst_n;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  act_sticky_a: assert property (act_q |=> act_q)
    else $error("activation bit cleared without reset");

  roll_fires_a: assert property (
    st_run && roll && (act_q || hw_watchdog_option) |-> ##2 !wdg_reset_n)
    else $error("rollover while active did not reset");

  idle_quiet_a: assert property (
    !act_q && !hw_watchdog_option && !sw_wr |=> !fire_q)
    else $error("reset fired while disabled");

  hold_ahalt_a: assert property (
    st_ahalt && !sw_wr |=> $stable(cnt_q))
    else $error("counter moved in active-halt");

  halt_reset_a: assert property (
    halt_go && !rtc_interrupt_enable && halt_reset_option && act_q |=> fire_q)
    else $error("halt with reset option did not fire");

  restart_wait_a: assert property (
    $rose(st_restart) |-> st_restart[*8])
    else $error("restart delay too short");

  ahalt_wake_a: assert property (
    st_ahalt && (ext_irq_wake || osc_irq_wake) |=> st_run)
    else $error("active-halt wake not immediate");

  free_run_a: assert property (
    tick && count_en && !sw_wr |=> cnt_q == $past(cnt_q) - 7'h01)
    else $error("counter missed a decrement");

  halted_frozen_a: assert property (
    st_halted && !sw_wr |=> !fire_q && $stable(cnt_q))
    else $error("halted watchdog moved or fired");

  pin_width_a: assert property (
    $fell(wdg_reset_n) |-> !wdg_reset_n[*8])
    else $error("reset pulse too short");

  sw_force_a: assert property (
    st_run && sw_wr && wr_byte[`WRW_ACT_BIT] && !wr_byte[`WRW_TOP_BIT] |=> fire_q)
    else $error("forced reset not raised");

  // ==========================================================================
  // low-power sequencing, pin, activation, reload and rollover checks

  lowpow_quiet_a: assert property (
    !st_run |=> !fire_q)
    else $error("reset raised outside run state");

  restart_hold_a: assert property (
    st_restart && !sw_wr |=> $stable(cnt_q))
    else $error("counter moved during restart delay");

  restart_len_a: assert property (
    $rose(st_restart) |-> dly_q == (long_restart_sel ? 13'(`WRW_DLY_LONG - 1) : 13'(`WRW_DLY_SHORT - 1)))
    else $error("restart delay loaded with wrong length");

  restart_end_a: assert property (
    st_restart && dly_q == 13'h0000 |=> st_run)
    else $error("restart delay did not end");

  hw_active_a: assert property (
    hw_watchdog_option && st_run && roll |=> fire_q)
    else $error("hardware option rollover did not fire");

  act_write_a: assert property (
    sw_wr && wr_byte[`WRW_ACT_BIT] |=> act_q)
    else $error("activation bit write not taken");

  reload_value_a: assert property (
    sw_wr |=> cnt_q == 7'($past(wr_byte)))
    else $error("counter reload not taken");

  last_step_a: assert property (
    st_last && tick |=> st_halted)
    else $error("halt did not stop after one step");

  halted_wake_a: assert property (
    st_halted && ext_irq_wake |=> st_restart)
    else $error("external wake did not start restart");

  halted_stay_a: assert property (
    st_halted && !ext_irq_wake |=> st_halted)
    else $error("halt left without external wake");

  pin_cause_a: assert property (
    $fell(wdg_reset_n) |-> $past(fire_q))
    else $error("reset pin fell without a fire");

  pulse_end_a: assert property (
    $rose(wdg_reset_n) |-> $past(wdg_reset_n, 8) == 1'b0)
    else $error("reset pulse released too early");

endmodule

// *** verilog/wrw_params.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the watchdog
// Assumes: pclk is the oscillator clock and the cpu clock, 200 MHz
// Notes:   included by bare name
`ifndef WRW_PARAMS_SVH
`define WRW_PARAMS_SVH

// ==========================================================================
// register map
`define WRW_CTRL_IDX     10'h02A
`define WRW_CTRL_ADDR    {`WRW_CTRL_IDX, 2'b00}
`define WRW_ACT_BIT      7
`define WRW_TOP_BIT      6
`define WRW_CTRL_RST     8'h7F
`define WRW_ROLL_FROM    7'h40

// ==========================================================================
// timing
`define WRW_OSC_DIV      16384
`define WRW_CLK_MHZ      200
`define WRW_RST_PULSE_NS 500
`define WRW_RST_CYC      ((`WRW_RST_PULSE_NS * `WRW_CLK_MHZ) / 1000)
`define WRW_DLY_SHORT    256
`define WRW_DLY_LONG     4096

`endif

// *** verilog/wrw_pkg.sv ***
// Purpose: types shared by the watchdog modules
// Assumes: nothing
// Notes:   one-hot power state codes
package wrw_pkg;

  // ==========================================================================
  // power state of the watchdog
  typedef enum logic [4:0] {
    WRW_RUN       = 5'h01,
    WRW_HALT_LAST = 5'h02,
    WRW_HALTED    = 5'h04,
    WRW_ACT_HALT  = 5'h08,
    WRW_RESTART   = 5'h10
  } wrw_state_t;

  typedef logic [6:0]  wrw_cnt_t;
  typedef logic [12:0] wrw_dly_t;

endpackage

// *** verilog/wrw_ctl_if.sv ***
// Purpose: signals between the watchdog core, its prescaler and its reset stretcher
// Assumes: single clock pclk
// Notes:   none
`timescale 1ns/1ps

interface wrw_ctl_if;
  logic count_en;
  logic tick;
  logic fire;
  logic rst_n;
  modport presc (input count_en, output tick);
  modport pulse (input fire, output rst_n);
endinterface

// *** verilog/wrw_prescaler.sv ***
// Purpose: divides the oscillator clock into the countdown tick
// Assumes: count_en low freezes the divider, as halt stops the oscillator path
// Notes:   the phase is unknown to software, hence the timeout spread
`timescale 1ns/1ps
`include "wrw_params.svh"

module wrw_prescaler #(
  parameter int DIV = `WRW_OSC_DIV
) (
  input  wire logic  pclk,    // oscillator clock
  input  wire logic  presetn, // async reset, low
  wrw_ctl_if.presc   ctl      // enable in, tick out
);

  localparam int W = $clog2(DIV);

  logic [W-1:0] div_q;
  logic         tick_q;
  wire          wrap = (div_q == W'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= ctl.count_en & wrap;
      if (ctl.count_en) begin
        div_q <= wrap ? '0 : div_q + 1'b1;
      end
    end
  end

  assign ctl.tick = tick_q;

endmodule

// *** verilog/wrw_reset_pulse.sv ***
// Purpose: stretches a watchdog fire into a fixed low pulse on the reset pin
// Assumes: the system reset logic answers the pulse
// Notes:   a fire during a pulse is absorbed by it
`timescale 1ns/1ps
`include "wrw_params.svh"

module wrw_reset_pulse (
  input  wire logic pclk,    // clock
  input  wire logic presetn, // async reset, low
  wrw_ctl_if.pulse  ctl      // fire in, reset pin out
);

  localparam logic [6:0] LAST = 7'(`WRW_RST_CYC - 1);

  logic [6:0] len_q;
  logic       rst_n_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_q   <= 7'h00;
      rst_n_q <= 1'b1;
    end else if (rst_n_q) begin
      rst_n_q <= ~ctl.fire;
      len_q   <= 7'h00;
    end else begin
      len_q   <= len_q + 7'h01;
      rst_n_q <= (len_q == LAST);
    end
  end

  assign ctl.rst_n = rst_n_q;

endmodule

// *** bench/wrw_sys_reset_model.sv ***
// Purpose: system reset logic on the far side of the watchdog reset pin
// Assumes: the pin is registered on pclk
// Notes:   counts pulses at their first low cycle, keeps the last low width
`timescale 1ns/1ps

module wrw_sys_reset_model (
  input  wire logic        pclk,        // clock
  input  wire logic        wdg_reset_n, // reset pin from the watchdog
  output logic      [7:0]  fire_cnt,    // pulses seen
  output logic      [15:0] last_width   // low cycles of the last pulse
);
  logic [15:0] run_q;

  initial begin
    fire_cnt = 8'h00;
    last_width = 16'h0000;
    run_q = 16'h0000;
  end

  // ==========================================================================
  // pulse counting, the pin is the only request the watchdog raises
  always @(posedge pclk) begin
    if (wdg_reset_n === 1'b0) begin
      if (run_q == 16'h0000) begin
        fire_cnt <= fire_cnt + 8'h01;
      end
      run_q <= run_q + 16'h0001;
    end else if (run_q != 16'h0000) begin
      last_width <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule

// *** bench/tb_wrw_watchdog.sv ***
// Purpose: self-checking bench for the watchdog over apb
// Assumes: OSC_DIV shortened to 16, pready answers without wait states
// Notes:   the bench plays the cpu software and the reset logic
`timescale 1ns/1ps
`include "wrw_params.svh"

module tb_wrw_watchdog;
  localparam int DIV = 16;
  localparam logic [11:0] A = `WRW_CTRL_ADDR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdg_reset_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic halt_insn, ext_irq_wake, osc_irq_wake, rtc_interrupt_enable;
  logic halt_reset_option, hw_watchdog_option, long_restart_sel, active_halt_reset_strap;
  logic er;
  logic [6:0] v1;
  logic [7:0] fire_cnt, f0;
  logic [15:0] last_width;
  int error_cnt, checks, n, cyc_cnt;

  wrw_watchdog #(.OSC_DIV(DIV)) wrw_watchdog_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_insn(halt_insn), .ext_irq_wake(ext_irq_wake), .osc_irq_wake(osc_irq_wake),
    .rtc_interrupt_enable(rtc_interrupt_enable), .halt_reset_option(halt_reset_option),
    .hw_watchdog_option(hw_watchdog_option), .long_restart_sel(long_restart_sel),
    .active_halt_reset_strap(active_halt_reset_strap), .wdg_reset_n(wdg_reset_n));

  wrw_sys_reset_model wrw_sys_reset_model_i (
    .pclk(pclk), .wdg_reset_n(wdg_reset_n), .fire_cnt(fire_cnt), .last_width(last_width));

  // ==========================================================================
  // tasks
  task test_done();
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic ok, input logic [31:0] got);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t unexpected value %h", $time, got);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // entered just after a rising edge; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // k selects the pulsed input: 0 halt, 1 external wake, 2 oscillator wake
  task pulse(input int k);
    if (k == 0) halt_insn <= 1'b1;
    else if (k == 1) ext_irq_wake <= 1'b1;
    else osc_irq_wake <= 1'b1;
    @(posedge pclk);
    {halt_insn, ext_irq_wake, osc_irq_wake} <= 3'b000;
  endtask

  task wait_fire(input int maxc);
    n = 0;
    f0 = fire_cnt;
    while (fire_cnt === f0 && n < maxc) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task do_reset();
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ==========================================================================
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end

  // ==========================================================================
  // scenarios
  initial begin
    {presetn, psel, penable, pwrite, halt_insn, ext_irq_wake, osc_irq_wake} = 7'h00;
    {rtc_interrupt_enable, halt_reset_option, hw_watchdog_option} = 3'h0;
    {long_restart_sel, active_halt_reset_strap} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {error_cnt, checks, cyc_cnt} = 0;
    do_reset();
    apb(0, A, 32'h0); chk(rd === 32'h7F && er === 1'b0, rd);
    apb(1, 12'h0AC, 32'hFF); apb(0, 12'h0AC, 32'h0); chk(rd === 32'h0 && er === 1'b1, rd);
    apb(0, A, 32'h0); chk(rd[7] === 1'b0, rd);
    v1 = rd[6:0];
    cyc(10 * DIV); apb(0, A, 32'h0); chk(v1 - rd[6:0] >= 9 && v1 - rd[6:0] <= 11, rd);
    f0 = fire_cnt;
    apb(1, A, 32'h41); cyc(5 * DIV); apb(0, A, 32'h0); chk(fire_cnt === f0 && rd[6:0] < 7'h3F, rd);
    apb(1, A, 32'hFF); apb(1, A, 32'h7F); apb(0, A, 32'h0); chk(rd === 32'hFF || rd === 32'hFE, rd);
    apb(1, A, 32'hC1); wait_fire(4 * DIV); chk(n >= DIV - 1 && n <= 2 * DIV + 4, n);
    cyc(`WRW_RST_CYC + 10); chk(last_width === `WRW_RST_CYC, last_width);
    do_reset();
    apb(1, A, 32'hBF); wait_fire(10); chk(n < 10, n);
    do_reset();
    halt_reset_option <= 1'b1;
    apb(1, A, 32'hFF); pulse(0); wait_fire(10); chk(n < 10, n);
    halt_reset_option <= 1'b0;
    do_reset();
    apb(1, A, 32'hFF); f0 = fire_cnt; pulse(0);
    cyc(3 * DIV); apb(0, A, 32'h0); v1 = rd[6:0]; chk(v1 === 7'h7E || v1 === 7'h7D, rd);
    cyc(20 * DIV); apb(0, A, 32'h0); chk(rd[6:0] === v1 && fire_cnt === f0, rd);
    pulse(1); cyc(200); apb(0, A, 32'h0); chk(rd[6:0] === v1, rd);
    cyc(120); apb(0, A, 32'h0); chk(rd[6:0] < v1, rd);
    do_reset();
    rtc_interrupt_enable <= 1'b1;
    pulse(0); cyc(5); apb(0, A, 32'h0); v1 = rd[6:0];
    cyc(6 * DIV); apb(0, A, 32'h0); chk(rd[6:0] === v1, rd);
    pulse(2); cyc(40); apb(0, A, 32'h0); chk(v1 - rd[6:0] >= 2 && v1 - rd[6:0] <= 3, rd);
    pulse(0); cyc(5); apb(0, A, 32'h0); v1 = rd[6:0];
    pulse(1); cyc(40); apb(0, A, 32'h0); chk(v1 - rd[6:0] >= 2 && v1 - rd[6:0] <= 3, rd);
    rtc_interrupt_enable <= 1'b0;
    long_restart_sel <= 1'b1;
    active_halt_reset_strap <= 1'b1;
    do_reset();
    active_halt_reset_strap <= 1'b0;
    cyc(3900); apb(0, A, 32'h0); chk(rd === 32'h7F, rd);
    cyc(400); apb(0, A, 32'h0); chk(rd[6:0] < 7'h7F, rd);
    long_restart_sel <= 1'b0;
    do_reset();
    hw_watchdog_option <= 1'b1;
    apb(1, A, 32'h41); wait_fire(4 * DIV); chk(n < 4 * DIV, n);
    apb(0, A, 32'h0); chk(rd[7] === 1'b0, rd);
    pulse(0); cyc(3 * DIV);
    hw_watchdog_option <= 1'b0;
    do_reset();
    apb(0, A, 32'h0); chk(rd === 32'h7F, rd);
    test_done();
  end
endmodule
